// [core/eiu_ext_irq_upper.sv]
/*
 * eiu_ext_irq_upper: external interrupt detection for general pins 4 to 7,
 * with configuration, flag clear, status and mask registers on AHB-Lite.
 * assumes: one 250 MHz clock, synchronous active-low reset, a single AHB-Lite
 * master doing single word transfers, pins asynchronous to clk.
 */
`timescale 1ns/1ps
module eiu_ext_irq_upper #(
    parameter int NUM_PINS = eiu_pkg::NUM_PINS
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // general pins 4 to 7
    input  wire logic [NUM_PINS-1:0]  general_pin,
    // outputs to the device
    output logic                      irq,
    output logic                      wake_request
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [15:0]          cfg_ff, nxt_cfg;
    logic                 autoclr_ff, nxt_autoclr;
    logic [NUM_PINS-1:0]  flag_ff, nxt_flag;
    logic [NUM_PINS-1:0]  status_ff, nxt_status;
    logic [NUM_PINS-1:0]  mask_ff, nxt_mask;
    logic                 wr_pend_ff, nxt_wr_pend;
    logic                 rd_pend_ff, nxt_rd_pend;
    logic [11:0]          addr_ff, nxt_addr;
    logic [31:0]          rdata_ff, nxt_rdata;
    logic                 wake_ff, nxt_wake;

    logic [NUM_PINS-1:0]  event_pulse;
    logic [NUM_PINS-1:0]  pin_en;
    logic [NUM_PINS-1:0]  clr_req;
    logic                 addr_phase;
    logic                 wr_cfg, wr_clr, wr_mask, rd_status;

    // enable bit of pin field i
    function automatic logic field_en(input logic [15:0] cfg, input int i);
        field_en = cfg[i*eiu_pkg::FIELD_W + eiu_pkg::EN_POS];
    endfunction

    // mode field of pin field i
    function automatic eiu_pkg::eiu_mode_e field_mode(input logic [15:0] cfg, input int i);
        field_mode = eiu_pkg::eiu_mode_e'(cfg[i*eiu_pkg::FIELD_W +: eiu_pkg::MODE_W]);
    endfunction

    // ****************************************************************
    // per-pin detectors
    // ****************************************************************
    // pin 4 sits in bits 3:0, pin 5 in 7:4, pin 6 in 11:8, pin 7 in 15:12
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        assign pin_en[g] = field_en(cfg_ff, g);
        eiu_pin_detect u_detect (
            .clk         (clk),
            .resetn      (resetn),
            .pin_in      (general_pin[g]),
            .enable      (pin_en[g]),
            .mode        (field_mode(cfg_ff, g)),
            .event_pulse (event_pulse[g])
        );
    end

    // ****************************************************************
    // ahb-lite decode; zero wait states, every response okay
    // ****************************************************************
    assign addr_phase = hsel & hready & htrans[1];
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_ff;

    assign wr_cfg    = wr_pend_ff & (addr_ff == eiu_pkg::ADDR_CONFIG_UPPER);
    assign wr_clr    = wr_pend_ff & (addr_ff == eiu_pkg::ADDR_FLAG_CLEAR);
    assign wr_mask   = wr_pend_ff & (addr_ff == eiu_pkg::ADDR_IRQ_MASK);
    assign rd_status = addr_phase & ~hwrite & (haddr[11:0] == eiu_pkg::ADDR_IRQ_STATUS);

    // clear strobes exist for one cycle only, so the clear bits read back as zero
    assign clr_req = wr_clr ? hwdata[eiu_pkg::CLR_LSB +: NUM_PINS] : '0;

    // ****************************************************************
    // bus pipeline and read mux
    // ****************************************************************
    always_comb begin
        nxt_wr_pend = addr_phase & hwrite;
        nxt_rd_pend = addr_phase & ~hwrite;
        nxt_addr    = addr_phase ? haddr[11:0] : addr_ff;
        nxt_rdata   = rdata_ff;
        // writable registers are read through their next values, so a read
        // pipelined right behind a write to the same register sees the new word
        if (addr_phase && !hwrite) begin
            unique case (haddr[11:0])
                eiu_pkg::ADDR_CONFIG_UPPER: nxt_rdata = {16'h0000, nxt_cfg};
                eiu_pkg::ADDR_FLAG_CLEAR:   nxt_rdata = 32'(nxt_autoclr) << eiu_pkg::AUTOCLR_POS;
                eiu_pkg::ADDR_IRQ_STATUS:   nxt_rdata = {28'h0000000, status_ff};
                eiu_pkg::ADDR_IRQ_MASK:     nxt_rdata = {28'h0000000, nxt_mask};
                eiu_pkg::ADDR_PIN_FLAGS:    nxt_rdata = (32'(wake_ff) << eiu_pkg::WAKE_POS)
                                                        | {28'h0000000, flag_ff};
                default:                    nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff    <= 12'h000;
            rdata_ff   <= 32'h00000000;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            rd_pend_ff <= nxt_rd_pend;
            addr_ff    <= nxt_addr;
            rdata_ff   <= nxt_rdata;
        end
    end

    // ****************************************************************
    // configuration, autoclear and mask registers
    // ****************************************************************
    always_comb begin
        nxt_cfg     = wr_cfg ? hwdata[eiu_pkg::CFG_W-1:0] : cfg_ff;
        nxt_mask    = wr_mask ? hwdata[NUM_PINS-1:0] : mask_ff;
        nxt_autoclr = wr_clr ? hwdata[eiu_pkg::AUTOCLR_POS] : autoclr_ff;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg_ff     <= eiu_pkg::CFG_RESET;
            mask_ff    <= eiu_pkg::MASK_RESET;
            autoclr_ff <= eiu_pkg::AUTOCLR_RESET;
        end else begin
            cfg_ff     <= nxt_cfg;
            mask_ff    <= nxt_mask;
            autoclr_ff <= nxt_autoclr;
        end
    end

    // ****************************************************************
    // latched flags, sticky status and wake request
    // ****************************************************************
    // a new event in the clearing cycle wins, so no event is ever lost.
    // with autoclear off the clear bits are ignored and flags stay latched
    // until the pin's enable is dropped.
    always_comb begin
        nxt_flag   = (flag_ff & ~(clr_req & {NUM_PINS{autoclr_ff}}) & pin_en) | event_pulse;
        nxt_status = (rd_status ? '0 : status_ff) | event_pulse;
        nxt_wake   = |(flag_ff & pin_en);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_ff   <= '0;
            status_ff <= '0;
            wake_ff   <= 1'b0;
        end else begin
            flag_ff   <= nxt_flag;
            status_ff <= nxt_status;
            wake_ff   <= nxt_wake;
        end
    end

    // level interrupt: any unmasked sticky status bit; no flag term, so only a status read or a mask write drops it
    assign irq          = |(status_ff & mask_ff);
    assign wake_request = wake_ff;

endmodule

// [pkg/eiu_pkg.sv]
/*
 * eiu_pkg: register map, field layout, reset values and detection mode codes
 * for the upper external interrupt detector (general pins 4 to 7).
 * assumes: a single 250 MHz clock domain and a 32-bit AHB-Lite register bus.
 */
package eiu_pkg;

    // ****************************************************************
    // register map (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [11:0] ADDR_CONFIG_UPPER = 12'ha24;  // external_irq_config_upper
    localparam logic [11:0] ADDR_FLAG_CLEAR   = 12'ha30;  // external_irq_flag_clear
    localparam logic [11:0] ADDR_IRQ_STATUS   = 12'ha40;  // sticky event status, clear on read
    localparam logic [11:0] ADDR_IRQ_MASK     = 12'ha44;  // status mask, same layout
    localparam logic [11:0] ADDR_PIN_FLAGS    = 12'ha48;  // latched flags and wake, read only

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam int          NUM_PINS          = 4;
    localparam int          MODE_W            = 3;
    localparam int          FIELD_W           = 4;        // enable bit plus mode field per pin
    localparam int          CFG_W             = 16;
    localparam int          EN_POS            = 3;        // enable bit inside a pin field
    localparam int          AUTOCLR_POS       = 14;       // pin_flag_autoclear_enable
    localparam int          CLR_LSB           = 4;        // clear bit of pin 4 in the clear register
    localparam int          WAKE_POS          = 8;        // wake request bit in the flags register
    localparam logic [15:0] CFG_RESET         = 16'h0000;
    localparam logic        AUTOCLR_RESET     = 1'h1;
    localparam logic [3:0]  MASK_RESET        = 4'h0;

    // ****************************************************************
    // detection mode codes
    // ****************************************************************
    typedef enum logic [2:0] {
        EIU_RISE      = 3'b000,
        EIU_FALL      = 3'b001,
        EIU_BOTH      = 3'b010,
        EIU_HIGH      = 3'b011,
        EIU_LOW       = 3'b100,
        EIU_FALL_ALT  = 3'b101,
        EIU_BOTH_ALT  = 3'b110,
        EIU_HIGH_ALT  = 3'b111
    } eiu_mode_e;

endpackage

// [core/eiu_pin_detect.sv]
/*
 * eiu_pin_detect: one pin's synchroniser and event detector.
 * assumes: pin_in is asynchronous to clk; mode and enable are stable register bits.
 */
`timescale 1ns/1ps
module eiu_pin_detect (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // pin and configuration
    input  wire logic                 pin_in,
    input  wire logic                 enable,
    input  wire eiu_pkg::eiu_mode_e   mode,
    // detected event
    output logic                      event_pulse
);

    logic sync1_ff, sync2_ff, prev_ff;
    logic nxt_sync1, nxt_sync2, nxt_prev;
    logic rise, fall;

    // ****************************************************************
    // two-stage synchroniser plus one history stage
    // ****************************************************************
    always_comb begin
        nxt_sync1 = pin_in;
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
    end

    // history resets low, so a pin already high at reset counts as rising once
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
        end
    end

    assign rise = sync2_ff & ~prev_ff;
    assign fall = ~sync2_ff & prev_ff;

    // ****************************************************************
    // mode decode; level modes fire every cycle the level persists
    // ****************************************************************
    always_comb begin
        event_pulse = 1'b0;
        if (enable) begin
            unique case (mode)
                eiu_pkg::EIU_RISE:     event_pulse = rise;
                eiu_pkg::EIU_FALL:     event_pulse = fall;
                eiu_pkg::EIU_FALL_ALT: event_pulse = fall;
                eiu_pkg::EIU_BOTH:     event_pulse = rise | fall;
                eiu_pkg::EIU_BOTH_ALT: event_pulse = rise | fall;
                eiu_pkg::EIU_HIGH:     event_pulse = sync2_ff;
                eiu_pkg::EIU_HIGH_ALT: event_pulse = sync2_ff;
                eiu_pkg::EIU_LOW:      event_pulse = ~sync2_ff;
            endcase
        end
    end

endmodule

// [testbench/eiu_ext_irq_upper_sva.sv]
/*
 * eiu_ext_irq_upper_sva: port checker for the upper external interrupt block.
 * assumes: bound into eiu_ext_irq_upper; config and mask are shadowed from bus writes.
 */
`timescale 1ns/1ps
module eiu_ext_irq_upper_sva #(
    parameter int NUM_PINS = eiu_pkg::NUM_PINS
) (
    // clock and reset
    input wire logic                clk,
    input wire logic                resetn,
    // ahb-lite
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    // pins and device outputs
    input wire logic [NUM_PINS-1:0] general_pin,
    input wire logic                irq,
    input wire logic                wake_request
);
    logic        wc_ff, wm_ff, rc_ff, hi5, lo7;
    logic [15:0] cfg_ff;
    logic [3:0]  msk_ff, en;
    // level conditions; all terms must hold together, so a stale config cannot pass
    always_comb begin
        en = {cfg_ff[15], cfg_ff[11], cfg_ff[7], cfg_ff[3]};
        hi5 = en[1] && cfg_ff[5:4] == 2'h3 && msk_ff[1] && general_pin[1];
        lo7 = en[3] && cfg_ff[14:12] == 3'h4 && msk_ff[3] && !general_pin[3];
    end
    // shadows load at the data phase edge, the same edge the slave uses
    always_ff @(posedge clk) begin
        if (!resetn) begin
            {wc_ff, wm_ff, rc_ff, cfg_ff, msk_ff} <= '0;
        end else begin
            wc_ff <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == eiu_pkg::ADDR_CONFIG_UPPER;
            wm_ff <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == eiu_pkg::ADDR_IRQ_MASK;
            rc_ff <= hsel && hready && htrans[1] && !hwrite && haddr[11:0] == eiu_pkg::ADDR_CONFIG_UPPER;
            cfg_ff <= wc_ff ? hwdata[15:0] : cfg_ff;
            msk_ff <= wm_ff ? hwdata[3:0] : msk_ff;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);
    cfg_readback_a: assert property (rc_ff |-> hrdata == {16'h0000, cfg_ff})
        else $error("config read differs from the value written");
    mask_gate_a: assert property (msk_ff == 4'h0 |-> !irq)
        else $error("irq high while every status bit is masked");
    enable_gate_a: assert property ((en == 4'h0) [*3] |-> !wake_request)
        else $error("wake request with every pin disabled");
    rise_pin4_a: assert property (en[0] && cfg_ff[2:0] == 3'h0 && msk_ff[0]
        && $rose(general_pin[0]) |-> ##[2:6] irq) else $error("rising edge on pin 4 gave no irq");
    fall_pin7_a: assert property (en[3] && cfg_ff[13:12] == 2'h1 && msk_ff[3]
        && $fell(general_pin[3]) |-> ##[2:6] irq) else $error("falling edge on pin 7 gave no irq");
    both_pin6_a: assert property (en[2] && cfg_ff[9:8] == 2'h2 && msk_ff[2]
        && $changed(general_pin[2]) |-> ##[2:6] irq) else $error("edge on pin 6 gave no irq");
    high_pin5_a: assert property (hi5 [*4] |-> ##[0:3] irq)
        else $error("high level on pin 5 gave no irq");
    low_pin7_a: assert property (lo7 [*4] |-> ##[0:3] irq)
        else $error("low level on pin 7 gave no irq");
    wake_seen_c: cover property (wake_request);
    level_hit_c: cover property (hi5 [*4]);
    irq_drop_c: cover property ($fell(irq));
endmodule
bind eiu_ext_irq_upper eiu_ext_irq_upper_sva #(.NUM_PINS(NUM_PINS)) u_sva (.clk(clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .general_pin(general_pin), .irq(irq), .wake_request(wake_request));

// [testbench/eiu_pin_src.sv]
/*
 * eiu_pin_src: behavioural source for general pins 4 to 7 (bits 0 to 3).
 * assumes: the bench calls drive(); pins are push-pull and never released.
 */
`timescale 1ns/1ps
module eiu_pin_src (
    // reference clock, only to place changes just after an edge
    input  wire logic  clk,
    // pins towards the block
    output logic [3:0] general_pin
);
    // start low, so leaving reset shows no edge
    initial general_pin = 4'h0;
    // a level holds until the next drive; no glitches are modelled
    task automatic drive(input int idx, input logic lvl);
        @(posedge clk);
        general_pin[idx] <= lvl;
    endtask
endmodule

// [testbench/eiu_ext_irq_upper_tb.sv]
/*
 * eiu_ext_irq_upper_tb: self-checking bench for the upper external interrupt block.
 * assumes: eiu_pin_src drives the pins; the checker binds itself in.
 */
`timescale 1ns/1ps
module eiu_ext_irq_upper_tb;
    logic        clk = 1'h0;
    logic        resetn = 1'h0;
    logic        hsel = 1'h0;
    logic        hwrite = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp, irq, wake_request;
    logic [31:0] hrdata, rv;
    logic [3:0]  general_pin;
    int          miscompares = 0;
    int          samples_checked = 0;
    // 250 mhz clock
    always #2 clk = ~clk;
    eiu_pin_src src (.clk(clk), .general_pin(general_pin));
    // hready loops back from the only slave
    eiu_ext_irq_upper dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .general_pin(general_pin), .irq(irq), .wake_request(wake_request));
    task automatic end_of_test();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for hready; a stuck bus ends the run
    task automatic rdy();
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'h1 && n < 40);
        if (hreadyout !== 1'h1) begin
            miscompares++;
            end_of_test();
        end
    endtask
    // single word transfer; read data is taken at the closing edge into rv
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rv = hrdata;
    endtask
    function automatic logic lvl(input logic [2:0] m, input logic x);
        return (m[1:0] == 2'h3) ? x : (m == 3'h4) ? !x : 1'h0;
    endfunction
    // one pin, one mode, one transition; third status read sees only a lasting level
    task automatic t_mode(input int p, input logic [2:0] m, input logic a);
        logic e;
        e = (m == 3'h0) ? !a : (m[1:0] == 2'h1) ? a : (m[1:0] == 2'h2);
        e = e | lvl(m, a) | lvl(m, !a);
        bus(1'h1, eiu_pkg::ADDR_IRQ_MASK, 32'h1 << p);
        bus(1'h1, eiu_pkg::ADDR_CONFIG_UPPER, {28'h0, 1'h1, m} << (4 * p));
        src.drive(p, a);
        repeat (6) @(posedge clk);
        bus(1'h0, eiu_pkg::ADDR_IRQ_STATUS, 32'h0);
        src.drive(p, !a);
        repeat (6) @(posedge clk);
        chk("irq", 32'(e), 32'(irq));
        bus(1'h0, eiu_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk("status", 32'(e) << p, rv);
        bus(1'h0, eiu_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk("level", 32'(lvl(m, !a)) << p, rv);
    endtask
    task automatic t_modes();
        for (int p = 0; p < 4; p++) begin
            for (int m = 0; m < 8; m++) begin
                t_mode(p, 3'(m), 1'h0);
                t_mode(p, 3'(m), 1'h1);
            end
        end
    endtask
    task automatic t_reset();
        chk("wake", 32'h0, 32'(wake_request));
        bus(1'h0, eiu_pkg::ADDR_CONFIG_UPPER, 32'h0);
        chk("config", 32'h0, rv);
        bus(1'h0, eiu_pkg::ADDR_FLAG_CLEAR, 32'h0);
        chk("clear", 32'h4000, rv);
        bus(1'h1, eiu_pkg::ADDR_CONFIG_UPPER, 32'hffffffff);
        bus(1'h0, eiu_pkg::ADDR_CONFIG_UPPER, 32'h0);
        chk("config", 32'hffff, rv);
        bus(1'h0, 12'ha50, 32'h0);
        chk("unmapped", 32'h0, rv);
    endtask
    // enables off, modes set to high level, all pins high: nothing may fire
    task automatic t_disabled();
        bus(1'h1, eiu_pkg::ADDR_IRQ_MASK, 32'hf);
        bus(1'h1, eiu_pkg::ADDR_CONFIG_UPPER, 32'h7777);
        bus(1'h0, eiu_pkg::ADDR_IRQ_STATUS, 32'h0);
        for (int p = 0; p < 4; p++) src.drive(p, 1'h1);
        repeat (6) @(posedge clk);
        bus(1'h0, eiu_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk("status", 32'h0, rv);
        for (int p = 0; p < 4; p++) src.drive(p, 1'h0);
    endtask
    // masked event: flag and wake set, irq low until unmasked; then write-1 clear
    task automatic t_flags();
        bus(1'h1, eiu_pkg::ADDR_IRQ_MASK, 32'h0);
        bus(1'h1, eiu_pkg::ADDR_CONFIG_UPPER, 32'h0008);
        bus(1'h0, eiu_pkg::ADDR_IRQ_STATUS, 32'h0);
        src.drive(0, 1'h1);
        repeat (6) @(posedge clk);
        chk("irq", 32'h0, 32'(irq));
        bus(1'h0, eiu_pkg::ADDR_PIN_FLAGS, 32'h0);
        chk("flags", 32'h101, rv);
        bus(1'h1, eiu_pkg::ADDR_IRQ_MASK, 32'h1);
        // the mask lands at the closing edge; look once it has settled
        @(posedge clk);
        chk("irq", 32'h1, 32'(irq));
        bus(1'h1, eiu_pkg::ADDR_FLAG_CLEAR, 32'h4010);
        repeat (2) @(posedge clk);
        chk("wake", 32'h0, 32'(wake_request));
        bus(1'h0, eiu_pkg::ADDR_FLAG_CLEAR, 32'h0);
        chk("clear", 32'h4000, rv);
        bus(1'h0, eiu_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk("status", 32'h1, rv);
        chk("irq", 32'h0, 32'(irq));
        // autoclear off: a write-1 clear must leave a fresh flag latched
        bus(1'h1, eiu_pkg::ADDR_FLAG_CLEAR, 32'h0);
        src.drive(0, 1'h0);
        repeat (4) @(posedge clk);
        src.drive(0, 1'h1);
        repeat (6) @(posedge clk);
        bus(1'h1, eiu_pkg::ADDR_FLAG_CLEAR, 32'h0010);
        bus(1'h0, eiu_pkg::ADDR_PIN_FLAGS, 32'h0);
        chk("flags", 32'h101, rv);
        bus(1'h0, eiu_pkg::ADDR_FLAG_CLEAR, 32'h0);
        chk("clear", 32'h0, rv);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        t_reset();
        t_modes();
        t_disabled();
        t_flags();
        end_of_test();
    end
endmodule
